// [hdl/aop_pkg.sv]
package aop_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int NUM_LINES = 4;
	localparam int PORT_W = 8;
	localparam int COUNT_W = 26;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int NUM_SRC = 3;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_CLEAR = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_DIN_LO = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_DIN_HI = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_CNT_CFG = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_CNT_LIMIT = 5'h18;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_TRACK_BIT = 0;
	localparam int CTRL_POL_HIGH_BIT = 1;
	localparam int CLEAR_ALL_BIT = 4;
	localparam int CMP_REF_LSB = 0;
	localparam int CMP_MASK_LSB = 8;
	localparam int CMP_MISMATCH_BIT = 16;
	localparam int CMP_ENABLE_BIT = 17;
	localparam int CMP_NUM_LSB = 18;
	localparam int CMP_ASSIGNED_BIT = 20;
	localparam int CNT_ENABLE_BIT = 0;
	localparam int CNT_NUM_LSB = 1;
	localparam int CNT_ASSIGNED_BIT = 3;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_COND_LSB = 4;
	localparam int STAT_PIN_LSB = 8;
	localparam int STAT_SRC_LSB = 12;
	localparam int STAT_DIN_LSB = 16;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic RST_TRACK = 1'b0;
	localparam logic RST_POL_HIGH = 1'b0;
	localparam logic [1:0] DEFAULT_LINE = 2'h0;

	typedef struct packed {
		logic assigned;
		logic [1:0] line_num;
		logic enable;
		logic mismatch_alarm;
		logic [PORT_W-1:0] compare_care_mask;
		logic [PORT_W-1:0] compare_reference_byte;
	} aop_cmp_cfg_t;

	typedef struct packed {
		logic assigned;
		logic [1:0] line_num;
		logic enable;
		logic [COUNT_W-1:0] upper_limit;
	} aop_cnt_cfg_t;

	// one bit per source: 0 lower byte, 1 upper byte, 2 counter
	typedef struct packed {
		logic [NUM_SRC-1:0] src;
		logic [NUM_SRC*2-1:0] line_num;
	} aop_event_t;

	localparam aop_cmp_cfg_t RST_CMP_CFG = '0;
	localparam aop_cnt_cfg_t RST_CNT_CFG = '0;
endpackage : aop_pkg

// [hdl/aop_alarm_out.sv]
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Contract
// [R1] four alarm lines, each the OR of alarms on channels assigned to it
// [R2] one hold or follow mode shared by all four lines
// [R3] hold mode: set on first alarm, kept until clear, new scan or power-up
// [R4] follow mode: asserted only while a reading is beyond its limit
// [R5] follow mode: new scan also clears the lines
// [R6] clear one line or all lines anytime; reading memory untouched
// [R7] shared polarity: active-low or active-high for all four lines
// [R8] factory reset clears lines, polarity back to active-low, queue kept
// [R9] polarity change may toggle line levels immediately
// [R10] port XOR reference, AND mask; match alarms on zero, mismatch on nonzero
// [R11] zero mask bits make the port bit a don't-care
// [R12] each bit zero, one or don't-care; change or exact pattern alarm
// [R13] counter alarms when count reaches enabled upper limit
// [R14] digital and counter alarms evaluated continuously once enabled
// [R15] digital and counter alarms go to reading memory only during scan
// [R16] new scan clears reading memory, keeps queued digital/counter alarms
// [R17] s01 lower input byte, s02 upper input byte, s03 counter
// [R18] compare alarm evaluated only after its check is enabled
// [R19] unassigned channel reports on alarm line one
// [R20] queue entry only on crossing into alarm, not while outside or on return
// [R21] polarity applied after the hold or follow logic
module aop_alarm_out (
	input wire logic clk,
	input wire logic rst,
	input wire logic [aop_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [aop_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [aop_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic factory_reset,
	input wire logic scan_start,
	input wire logic scan_running,
	input wire logic [aop_pkg::NUM_LINES-1:0] meas_alarm_cond,
	input wire logic [aop_pkg::PORT_W-1:0] din_lo_pin,
	input wire logic [aop_pkg::PORT_W-1:0] din_hi_pin,
	input wire logic [aop_pkg::COUNT_W-1:0] count_value,
	output logic [aop_pkg::NUM_LINES-1:0] alarm_out,
	output logic queue_push,
	output aop_pkg::aop_event_t queue_entry,
	output logic mem_push,
	output aop_pkg::aop_event_t mem_entry,
	output logic mem_clear
);
	import aop_pkg::*;

	// ****************************************
	// bus slave
	// ****************************************
	logic ack_reg;
	logic wr_en;
	logic [DATA_W-1:0] readdata_reg;
	logic [DATA_W-1:0] read_mux;
	localparam int CMP_W = $bits(aop_cmp_cfg_t);

	// one wait cycle: answer at the second edge of the request
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr_en = avs_write & ack_reg;
	assign avs_readdata = readdata_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read | avs_write) & ~ack_reg;
		end
	end

	function automatic logic [DATA_W-1:0] merge_bytes(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [3:0] be
	);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

	// ****************************************
	// configuration registers
	// ****************************************
	logic track_mode_reg;
	logic pol_high_reg;
	aop_cmp_cfg_t cmp_cfg_reg [2];
	aop_cnt_cfg_t cnt_cfg_reg;
	logic [NUM_LINES-1:0] clear_pulse;

	always_ff @(posedge clk) begin
		if (rst) begin
			track_mode_reg <= RST_TRACK;
			pol_high_reg <= RST_POL_HIGH;
		end else if (factory_reset) begin
			// [R8] polarity to active-low
			pol_high_reg <= RST_POL_HIGH;
		end else if (wr_en && avs_address == OFS_CTRL && avs_byteenable[0]) begin
			// [R2] single shared mode
			track_mode_reg <= avs_writedata[CTRL_TRACK_BIT];
			// [R9] no glitch suppression on polarity change
			pol_high_reg <= avs_writedata[CTRL_POL_HIGH_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_cfg_reg[0] <= RST_CMP_CFG;
			cmp_cfg_reg[1] <= RST_CMP_CFG;
			cnt_cfg_reg <= RST_CNT_CFG;
		end else if (wr_en) begin
			case (avs_address)
				OFS_DIN_LO: begin
					cmp_cfg_reg[0] <= CMP_W'(merge_bytes(DATA_W'(cmp_cfg_reg[0]), avs_writedata,
						avs_byteenable));
				end
				OFS_DIN_HI: begin
					cmp_cfg_reg[1] <= CMP_W'(merge_bytes(DATA_W'(cmp_cfg_reg[1]), avs_writedata,
						avs_byteenable));
				end
				OFS_CNT_CFG: begin
					if (avs_byteenable[0]) begin
						cnt_cfg_reg.enable <= avs_writedata[CNT_ENABLE_BIT];
						cnt_cfg_reg.line_num <= avs_writedata[CNT_NUM_LSB +: 2];
						cnt_cfg_reg.assigned <= avs_writedata[CNT_ASSIGNED_BIT];
					end
				end
				OFS_CNT_LIMIT: begin
					cnt_cfg_reg.upper_limit <= COUNT_W'(merge_bytes(
						DATA_W'(cnt_cfg_reg.upper_limit), avs_writedata, avs_byteenable));
				end
				default: begin
				end
			endcase
		end
	end

	// [R6] write-one-to-clear, one line or all
	always_comb begin
		clear_pulse = '0;
		if (wr_en && avs_address == OFS_CLEAR && avs_byteenable[0]) begin
			clear_pulse = avs_writedata[NUM_LINES-1:0];
			if (avs_writedata[CLEAR_ALL_BIT]) begin
				clear_pulse = '1;
			end
		end
	end

	// ****************************************
	// digital input synchronisers
	// ****************************************
	logic [2*PORT_W-1:0] din_raw;
	logic [2*PORT_W-1:0] sync1_reg;
	logic [2*PORT_W-1:0] sync2_reg;
	logic [2*PORT_W-1:0] sync3_reg;
	logic [2*PORT_W-1:0] din_reg;

	// [R17] low half is s01, high half is s02
	assign din_raw = {din_hi_pin, din_lo_pin};

	genvar gb;
	generate
		for (gb = 0; gb < 2*PORT_W; gb++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					sync1_reg[gb] <= 1'b0;
					sync2_reg[gb] <= 1'b0;
					sync3_reg[gb] <= 1'b0;
					din_reg[gb] <= 1'b0;
				end else begin
					sync1_reg[gb] <= din_raw[gb];
					sync2_reg[gb] <= sync1_reg[gb];
					sync3_reg[gb] <= sync2_reg[gb];
					// accept a change only once two stages agree
					if (sync2_reg[gb] == sync3_reg[gb]) begin
						din_reg[gb] <= sync3_reg[gb];
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// source alarm evaluation
	// ****************************************
	logic [NUM_SRC-1:0] src_cond;
	logic [NUM_SRC-1:0] src_cond_reg;
	logic [NUM_SRC-1:0] src_rise;
	logic [NUM_SRC*2-1:0] src_line;

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_cmp
			logic [PORT_W-1:0] diff;
			// [R10] xor with reference, and with mask
			// [R11] zero mask bits drop out of the compare
			assign diff = (din_reg[gp*PORT_W +: PORT_W] ^ cmp_cfg_reg[gp].compare_reference_byte)
				& cmp_cfg_reg[gp].compare_care_mask;
			// [R12] mismatch covers bit changes, match an exact pattern
			// [R18] disabled compare never alarms
			// [R14] evaluated regardless of scan state
			assign src_cond[gp] = cmp_cfg_reg[gp].enable &
				(cmp_cfg_reg[gp].mismatch_alarm ? (diff != '0) : (diff == '0));
			// [R19] unassigned goes to line one
			assign src_line[gp*2 +: 2] = cmp_cfg_reg[gp].assigned ?
				cmp_cfg_reg[gp].line_num : DEFAULT_LINE;
		end
	endgenerate

	// [R13] reaching the limit, once the check is on
	assign src_cond[2] = cnt_cfg_reg.enable & (count_value >= cnt_cfg_reg.upper_limit);
	// [R19] unassigned goes to line one
	assign src_line[5:4] = cnt_cfg_reg.assigned ? cnt_cfg_reg.line_num : DEFAULT_LINE;

	always_ff @(posedge clk) begin
		if (rst) begin
			src_cond_reg <= '0;
		end else begin
			src_cond_reg <= src_cond;
		end
	end

	// [R20] only the crossing counts as an event
	assign src_rise = src_cond & ~src_cond_reg;

	// ****************************************
	// queue and reading memory ports
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			queue_push <= 1'b0;
			queue_entry <= '0;
		end else begin
			// [R20] log on crossing only
			queue_push <= |src_rise;
			if (|src_rise) begin
				queue_entry.src <= src_rise;
				queue_entry.line_num <= src_line;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mem_push <= 1'b0;
			mem_entry <= '0;
			mem_clear <= 1'b0;
		end else begin
			// [R16] scan start wipes reading memory, the queue has no clear here
			mem_clear <= scan_start;
			// [R15] memory sees these alarms only while scanning
			mem_push <= (|src_rise) & scan_running;
			if ((|src_rise) & scan_running) begin
				mem_entry.src <= src_rise;
				mem_entry.line_num <= src_line;
			end
		end
	end

	// ****************************************
	// per-line hold and follow
	// ****************************************
	logic [NUM_LINES-1:0] line_cond;
	logic [NUM_LINES-1:0] line_cond_reg;
	logic [NUM_LINES-1:0] state_reg;

	genvar gl;
	generate
		for (gl = 0; gl < NUM_LINES; gl++) begin : g_line
			logic [NUM_SRC-1:0] hit;
			logic line_rise;
			logic line_clear;
			for (genvar gs = 0; gs < NUM_SRC; gs++) begin : g_hit
				assign hit[gs] = src_cond[gs] & (src_line[gs*2 +: 2] == 2'(gl));
			end
			// [R1] OR across every channel on this line
			assign line_cond[gl] = meas_alarm_cond[gl] | (|hit);
			assign line_rise = line_cond[gl] & ~line_cond_reg[gl];
			// [R3] [R5] scan start clears in both modes
			// [R6] manual clear leaves memory alone
			// [R8] factory reset clears the line
			assign line_clear = clear_pulse[gl] | scan_start | factory_reset;

			always_ff @(posedge clk) begin
				if (rst) begin
					line_cond_reg[gl] <= 1'b0;
				end else begin
					line_cond_reg[gl] <= line_cond[gl];
				end
			end

			// a new crossing in the clear cycle is kept: set wins
			always_ff @(posedge clk) begin
				if (rst) begin
					state_reg[gl] <= 1'b0;
				end else if (line_rise) begin
					// [R3] latch on the first alarm
					state_reg[gl] <= 1'b1;
				end else if (line_clear) begin
					state_reg[gl] <= 1'b0;
				end else if (track_mode_reg && !line_cond[gl]) begin
					// [R4] follow mode drops once back in limits
					state_reg[gl] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// output polarity
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			// idle level for active-low lines
			alarm_out <= '1;
		end else begin
			// [R7] shared polarity
			// [R21] inversion sits after the state, never inside it
			alarm_out <= pol_high_reg ? state_reg : ~state_reg;
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		read_mux = '0;
		case (avs_address)
			OFS_CTRL: begin
				read_mux[CTRL_TRACK_BIT] = track_mode_reg;
				read_mux[CTRL_POL_HIGH_BIT] = pol_high_reg;
			end
			OFS_STATUS: begin
				read_mux[STAT_STATE_LSB +: NUM_LINES] = state_reg;
				read_mux[STAT_COND_LSB +: NUM_LINES] = line_cond;
				read_mux[STAT_PIN_LSB +: NUM_LINES] = alarm_out;
				read_mux[STAT_SRC_LSB +: NUM_SRC] = src_cond;
				read_mux[STAT_DIN_LSB +: 2*PORT_W] = din_reg;
			end
			OFS_DIN_LO: begin
				read_mux[$bits(aop_cmp_cfg_t)-1:0] = cmp_cfg_reg[0];
			end
			OFS_DIN_HI: begin
				read_mux[$bits(aop_cmp_cfg_t)-1:0] = cmp_cfg_reg[1];
			end
			OFS_CNT_CFG: begin
				read_mux[CNT_ENABLE_BIT] = cnt_cfg_reg.enable;
				read_mux[CNT_NUM_LSB +: 2] = cnt_cfg_reg.line_num;
				read_mux[CNT_ASSIGNED_BIT] = cnt_cfg_reg.assigned;
			end
			OFS_CNT_LIMIT: begin
				read_mux[COUNT_W-1:0] = cnt_cfg_reg.upper_limit;
			end
			default: begin
				read_mux = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			readdata_reg <= '0;
		end else if (avs_read && !ack_reg) begin
			readdata_reg <= read_mux;
		end
	end
endmodule : aop_alarm_out

// [verification/aop_alarm_out_props.sv]
`timescale 1ns/1ps
module aop_alarm_out_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic factory_reset,
	input wire logic scan_start,
	input wire logic scan_running,
	input wire logic [aop_pkg::NUM_LINES-1:0] alarm_out,
	input wire logic queue_push,
	input wire aop_pkg::aop_event_t queue_entry,
	input wire logic mem_push,
	input wire logic mem_clear
);
	import aop_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// a crossing on the reset edge would win, so only quiet resets count
	sequence s_fr_quiet;
		factory_reset ##1 !queue_push;
	endsequence
	a_one_wait: assert property (s_req_wait |=> !avs_waitrequest)
		else $error("waitrequest held too long");
	a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest while idle");
	a_factory_idle: assert property (s_fr_quiet |=> alarm_out == 4'hF)
		else $error("lines not idle after factory reset");
	a_mem_scan_gate: assert property (mem_push |-> $past(scan_running))
		else $error("memory push outside scan");
	a_mem_with_queue: assert property (mem_push |-> queue_push)
		else $error("memory push without queue push");
	a_scan_mem_clear: assert property (scan_start |=> mem_clear)
		else $error("no memory clear after scan start");
	a_clear_cause: assert property (mem_clear |-> $past(scan_start))
		else $error("memory clear without scan start");
	a_entry_source: assert property (queue_push |-> queue_entry.src != 3'h0)
		else $error("queue entry without source");
	a_entry_holds: assert property (!queue_push && !$past(rst) |-> $stable(queue_entry))
		else $error("queue entry changed without push");
endmodule : aop_alarm_out_props
bind aop_alarm_out aop_alarm_out_props u_props (.clk(clk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .factory_reset(factory_reset),
	.scan_start(scan_start), .scan_running(scan_running), .alarm_out(alarm_out),
	.queue_push(queue_push), .queue_entry(queue_entry), .mem_push(mem_push),
	.mem_clear(mem_clear));

// [verification/aop_lamp_model.sv]
`timescale 1ns/1ps
module aop_lamp_model (
	input wire logic active_high,
	input wire logic [aop_pkg::NUM_LINES-1:0] alarm_out,
	output logic [aop_pkg::NUM_LINES-1:0] lamp_on
);
	import aop_pkg::*;
	assign lamp_on = active_high ? alarm_out : ~alarm_out;
endmodule : aop_lamp_model

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import aop_pkg::*;
	logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address = '0;
	logic [DATA_W-1:0] avs_writedata = '0, avs_readdata, rd_q[$];
	logic factory_reset = 1'b0, scan_start = 1'b0, scan_running = 1'b0, pol_high = 1'b0;
	logic [NUM_LINES-1:0] meas_alarm_cond = '0, alarm_out, lamp_on;
	logic [PORT_W-1:0] din_lo_pin = '0, din_hi_pin = '0, ref_b;
	logic [COUNT_W-1:0] count_value = '0, lim;
	logic queue_push, mem_push, mem_clear;
	aop_event_t queue_entry, mem_entry;
	logic [5:0] push_q[$];
	logic [5:0] note;
	logic [3:0] avs_byteenable = 4'hF;
	int failures = 0, checks = 0, seed = 50;
	aop_alarm_out dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.factory_reset(factory_reset), .scan_start(scan_start), .scan_running(scan_running),
		.meas_alarm_cond(meas_alarm_cond), .din_lo_pin(din_lo_pin), .din_hi_pin(din_hi_pin),
		.count_value(count_value), .alarm_out(alarm_out), .queue_push(queue_push),
		.queue_entry(queue_entry), .mem_push(mem_push), .mem_entry(mem_entry),
		.mem_clear(mem_clear));
	aop_lamp_model lamps (.active_high(pol_high), .alarm_out(alarm_out), .lamp_on(lamp_on));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// ****************************************
	// avalon master and waits
	// ****************************************
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		input logic [31:0] exp);
		int n;
		n = 0;
		if (!wr) rd_q.push_back(exp);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// waitrequest judged at the rising edge, where the write lands
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			failures++;
			complete_run();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus
	// bounded: a line that never settles is reported, not waited on
	task automatic wait_lamp(input logic [3:0] exp);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (lamp_on !== exp && n < 40);
		check(lamp_on, exp);
		if (lamp_on !== exp) begin
			complete_run();
		end
		@(posedge clk);
	endtask : wait_lamp
	function automatic logic [1:0] line_of(input aop_event_t e);
		return e.src[0] ? e.line_num[1:0] : (e.src[1] ? e.line_num[3:2] : e.line_num[5:4]);
	endfunction : line_of
	// ****************************************
	// result watcher
	// ****************************************
	// read data taken at the edge where waitrequest is seen low
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			check(avs_readdata, rd_q.pop_front());
		end
		if (queue_push === 1'b1 && push_q.size() == 0) begin
			check(1'b1, 1'b0);
		end else if (queue_push === 1'b1) begin
			note = push_q.pop_front();
			check({mem_push, queue_entry.src, line_of(queue_entry)}, note);
			if (mem_push === 1'b1) begin
				check({mem_entry.src, line_of(mem_entry)}, note[4:0]);
			end
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		lim = 26'($random(seed)) | 26'h0000100;
		ref_b = 8'($random(seed));
		bus(1'b0, OFS_CTRL, '0, 32'h0);
		bus(1'b0, 5'h1C, '0, 32'h0);
		bus(1'b0, OFS_CLEAR, '0, 32'h0);
		check(alarm_out, 4'hF);
		bus(1'b1, OFS_CNT_LIMIT, 32'(lim), '0);
		count_value <= lim - 1'b1;
		bus(1'b1, OFS_CNT_CFG, 32'h1, '0);
		push_q.push_back(6'b0_100_00);
		count_value <= lim;
		wait_lamp(4'h1);
		count_value <= lim - 1'b1;
		repeat (8) @(posedge clk);
		check(lamp_on, 4'h1);
		bus(1'b1, OFS_CLEAR, 32'h1, '0);
		wait_lamp(4'h0);
		meas_alarm_cond <= 4'h8;
		wait_lamp(4'h8);
		meas_alarm_cond <= 4'h0;
		bus(1'b1, OFS_CLEAR, 32'h10, '0);
		wait_lamp(4'h0);
		din_lo_pin <= 8'h8B;
		bus(1'b1, OFS_DIN_LO, 32'h0018F080, '0);
		repeat (10) @(posedge clk);
		check(lamp_on, 4'h0);
		push_q.push_back(6'b0_001_10);
		bus(1'b1, OFS_DIN_LO, 32'h001AF080, '0);
		wait_lamp(4'h4);
		din_lo_pin <= 8'h92;
		bus(1'b1, OFS_CLEAR, 32'h10, '0);
		din_hi_pin <= ref_b;
		// let the pin filter settle before the compare is enabled
		repeat (6) @(posedge clk);
		bus(1'b1, OFS_DIN_HI, {11'h0, 1'b1, 2'h1, 1'b1, 1'b1, 8'hFF, ref_b}, '0);
		repeat (10) @(posedge clk);
		check(lamp_on, 4'h0);
		push_q.push_back(6'b0_010_01);
		din_hi_pin <= ref_b ^ 8'h04;
		wait_lamp(4'h2);
		din_hi_pin <= ref_b;
		bus(1'b1, OFS_CLEAR, 32'h2, '0);
		wait_lamp(4'h0);
		bus(1'b1, OFS_CTRL, 32'h1, '0);
		scan_running <= 1'b1;
		push_q.push_back(6'b1_100_00);
		count_value <= lim;
		wait_lamp(4'h1);
		count_value <= lim - 1'b1;
		wait_lamp(4'h0);
		push_q.push_back(6'b1_100_00);
		count_value <= lim;
		wait_lamp(4'h1);
		scan_start <= 1'b1;
		@(posedge clk);
		scan_start <= 1'b0;
		scan_running <= 1'b0;
		wait_lamp(4'h0);
		pol_high <= 1'b1;
		bus(1'b1, OFS_CTRL, 32'h3, '0);
		@(negedge clk);
		check(alarm_out, 4'h0);
		@(posedge clk);
		count_value <= lim - 1'b1;
		repeat (2) @(posedge clk);
		push_q.push_back(6'b0_100_00);
		count_value <= lim;
		wait_lamp(4'h1);
		factory_reset <= 1'b1;
		pol_high <= 1'b0;
		@(posedge clk);
		factory_reset <= 1'b0;
		wait_lamp(4'h0);
		avs_byteenable <= 4'h1;
		bus(1'b1, OFS_CNT_LIMIT, 32'hFFFFFFFF, '0);
		avs_byteenable <= 4'hF;
		bus(1'b0, OFS_CNT_LIMIT, '0, 32'({lim[25:8], 8'hFF}));
		bus(1'b0, OFS_CTRL, '0, 32'h1);
		check(push_q.size(), 0);
		complete_run();
	end
endmodule : testbench
